//--- rtl/framer_consts.svh
// register offsets, field positions, reset values and frame size limits of the framer
`ifndef FRAMER_CONSTS_SVH
`define FRAMER_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_PACKET_CONTROL_ONE  8'h04
`define IDX_PACKET_CONTROL_TWO  8'h05
`define IDX_DATA_SETTINGS_TWO   8'h08
`define IDX_FRAME_CONTROL       8'h10
`define IDX_TX_LENGTH           8'h11
`define IDX_FRAME_STATUS        8'h12
`define IDX_RX_LENGTH           8'h13

// field positions
`define EXT_SEL_A_MSB     7
`define EXT_SEL_A_LSB     6
`define RX_EXT_DIS_BIT    3
`define FMT_SEL_MSB       1
`define FMT_SEL_LSB       0
`define LEN_MODE_MSB      1
`define LEN_MODE_LSB      0
`define EXT_SEL_B_MSB     7
`define EXT_SEL_B_LSB     6
`define WHITEN_EN_BIT     0
`define CTRL_START_BIT    0
`define CTRL_TX_BIT       1
`define STAT_BUSY_BIT     0
`define STAT_DONE_BIT     1
`define STAT_LENERR_BIT   2
`define STAT_EXT_BIT      3

// field encodings
`define FMT_B             2'h1
`define FMT_C             2'h2
`define EXT_A_ELL         2'h0
`define EXT_B_CI8E        2'h1
`define EXT_B_CI8F        2'h2
`define LEN_MODE_TWO      2'h1
`define CI_EXT_8E         8'h8E
`define CI_EXT_8F         8'h8F

// byte positions and block sizes, counted from the first byte after the length field
`define CI_POS            11'h009
`define SEG_FIRST_PLAIN   8'h7D
`define SEG_FIRST_8F      8'h18
`define SEG_SECOND_8F     8'h63
`define SEG_OPTIONAL      8'h7E
`define CRC_BYTES         11'h002
`define MIN_LEN_B         11'h00C
`define PN9_SEED          9'h1FF

// reset values
`define RST_PACKET_CONTROL_ONE  8'h00
`define RST_PACKET_CONTROL_TWO  8'h00
`define RST_DATA_SETTINGS_TWO   8'h00

`endif

//--- rtl/framer_pkg.sv
// types shared by the framer modules
package framer_pkg;
  typedef enum logic [1:0] {
    kind_plain   = 2'b00,
    kind_ci8e    = 2'b01,
    kind_ci8f    = 2'b10,
    kind_general = 2'b11
  } frame_kind_type;

  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_len_hi = 3'b001,
    st_len_lo = 3'b010,
    st_body   = 3'b011,
    st_crc_a  = 3'b100,
    st_crc_b  = 3'b101
  } frame_state_type;
endpackage

//--- rtl/whiten_link_if.sv
// carrier between the frame engine and the whitening sequence generator
interface whiten_link_if;
  logic       init;
  logic       step;
  logic [7:0] din;
  logic [7:0] dout;
  modport engine   (output init, output step, output din, input dout);
  modport whitener (input init, input step, input din, output dout);
endinterface

//--- rtl/whitener.sv
// pn9 data whitening: the same xor applies whitening on transmit and removes it on receive
`include "framer_consts.svh"

module whitener (
  input  wire logic     pclk,
  input  wire logic     presetn,
  whiten_link_if.whitener link
);
  logic [8:0] pn;
  logic [8:0] next_pn;
  logic [7:0] pn_byte;

  // eight steps of x^9 + x^5 + 1, first bit out is lsb of the byte
  always_comb begin
    next_pn = pn;
    pn_byte = 8'h00;
    for (int i = 0; i < 8; i++) begin
      pn_byte[i] = next_pn[0];
      next_pn    = {next_pn[0] ^ next_pn[5], next_pn[8:1]};
    end
  end

  assign link.dout = link.din ^ pn_byte;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pn <= `PN9_SEED;
    end else if (link.init) begin
      pn <= `PN9_SEED;
    end else if (link.step) begin
      pn <= next_pn;
    end
  end
endmodule // whitener

//--- rtl/extended_link_and_general_framer.sv
// byte-stream framer for meter-bus format b, its extended link layer frames and format c
// How it works
// [RULE1] software selects the 0x8E frame with select a = 00 and select b = 01
// [RULE2] software selects the 0x8F frame with select a = 00 and select b = 10
// [RULE3] receive checks the ci byte for extended frames unless the check is disabled
// [RULE4] extended frames keep the format b first block ahead of the extended block
// [RULE5] format select 10 picks general format c
// [RULE6] format c is one block closed by a two-byte crc
// [RULE7] format c length counts every byte after it, crc included
// [RULE8] format c length field is one or two bytes per length mode
// [RULE9] format c body is whitened on transmit and de-whitened on receive
// [RULE10] format select 01 picks meter-bus format b
// [RULE11] in format b each block from the second on ends in a two-byte crc
// [RULE12] block limits: 0x8E 125 then 126; 0x8F 24, 99, then 126
`include "framer_consts.svh"

module extended_link_and_general_framer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [7:0]  in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [7:0]  out_data,
  output logic             out_crc
);
  import framer_pkg::*;

  // ----------------------------------------------------------------
  // registers and apb access
  // ----------------------------------------------------------------
  logic [7:0]      packet_control_one;
  logic [7:0]      packet_control_two;
  logic [7:0]      data_settings_two;
  logic [10:0]     tx_length;
  logic [10:0]     len_q;
  logic            done_flag;
  logic            len_err_flag;
  logic            ext_seen;
  frame_state_type state;
  frame_kind_type  kind;
  logic            dir_tx;
  logic            white_on;
  logic [10:0]     remaining;
  logic [10:0]     pos;
  logic [7:0]      seg_cnt;
  logic [1:0]      seg_idx;
  logic            wr_en;
  logic            start;
  logic            mapped;
  logic            set_done;
  logic            set_err;
  logic [31:0]     rd_mux;

  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr == {2'b00, idx, 2'b00});
  endfunction

  function automatic logic [7:0] seg_limit(input frame_kind_type k, input logic [1:0] idx);
    if (k == kind_ci8f && idx == 2'd0) begin
      seg_limit = `SEG_FIRST_8F;  // [RULE12]
    end else if (k == kind_ci8f && idx == 2'd1) begin
      seg_limit = `SEG_SECOND_8F;  // [RULE12]
    end else if (idx == 2'd0) begin
      seg_limit = `SEG_FIRST_PLAIN;  // [RULE12]
    end else begin
      seg_limit = `SEG_OPTIONAL;  // [RULE12]
    end
  endfunction

  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    if (hit(paddr, `IDX_PACKET_CONTROL_ONE)) begin
      rd_mux[7:0] = packet_control_one;
    end else if (hit(paddr, `IDX_PACKET_CONTROL_TWO)) begin
      rd_mux[7:0] = packet_control_two;
    end else if (hit(paddr, `IDX_DATA_SETTINGS_TWO)) begin
      rd_mux[7:0] = data_settings_two;
    end else if (hit(paddr, `IDX_FRAME_CONTROL)) begin
      rd_mux[`CTRL_TX_BIT] = dir_tx;
    end else if (hit(paddr, `IDX_TX_LENGTH)) begin
      rd_mux[10:0] = tx_length;
    end else if (hit(paddr, `IDX_FRAME_STATUS)) begin
      // busy holds until done is visible, so a poll never sees neither
      rd_mux[`STAT_BUSY_BIT]   = (state != st_idle) || set_done;
      rd_mux[`STAT_DONE_BIT]   = done_flag;
      rd_mux[`STAT_LENERR_BIT] = len_err_flag;
      rd_mux[`STAT_EXT_BIT]    = ext_seen;
      rd_mux[9:8]              = kind;
    end else if (hit(paddr, `IDX_RX_LENGTH)) begin
      rd_mux[10:0] = len_q;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr = psel && penable && !mapped;

  // read data is captured in the setup cycle so it stands from a flip-flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      packet_control_one <= `RST_PACKET_CONTROL_ONE;
      packet_control_two <= `RST_PACKET_CONTROL_TWO;
      data_settings_two  <= `RST_DATA_SETTINGS_TWO;
      tx_length          <= 11'h000;
    end else if (wr_en && state == st_idle) begin
      // settings are frozen while a frame is in flight
      if (hit(paddr, `IDX_PACKET_CONTROL_ONE)) begin
        packet_control_one <= pwdata[7:0];
      end else if (hit(paddr, `IDX_PACKET_CONTROL_TWO)) begin
        packet_control_two <= pwdata[7:0];
      end else if (hit(paddr, `IDX_DATA_SETTINGS_TWO)) begin
        data_settings_two <= pwdata[7:0];
      end else if (hit(paddr, `IDX_TX_LENGTH)) begin
        tx_length <= pwdata[10:0];
      end
    end
  end

  assign start = wr_en && hit(paddr, `IDX_FRAME_CONTROL) && pwdata[`CTRL_START_BIT]
                 && state == st_idle;

  // sticky flags, write one to clear; a hardware set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag    <= 1'b0;
      len_err_flag <= 1'b0;
    end else begin
      if (set_done) begin
        done_flag <= 1'b1;
      end else if (wr_en && hit(paddr, `IDX_FRAME_STATUS) && pwdata[`STAT_DONE_BIT]) begin
        done_flag <= 1'b0;
      end
      if (set_err) begin
        len_err_flag <= 1'b1;
      end else if (wr_en && hit(paddr, `IDX_FRAME_STATUS) && pwdata[`STAT_LENERR_BIT]) begin
        len_err_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  whiten_link_if wl ();

  whitener u_whitener (
    .pclk    (pclk),
    .presetn (presetn),
    .link    (wl.whitener)
  );

  logic        can_load;
  logic        need_in;
  logic        step;
  logic [7:0]  cur_byte;
  logic [10:0] new_len;
  logic        len_bad;
  logic [1:0]  fmt;
  logic [1:0]  ext_a;
  logic [1:0]  ext_b;
  logic [10:0] rem_dec;
  logic [7:0]  seg_inc;

  assign fmt      = packet_control_one[`FMT_SEL_MSB:`FMT_SEL_LSB];
  assign ext_a    = packet_control_one[`EXT_SEL_A_MSB:`EXT_SEL_A_LSB];
  assign ext_b    = data_settings_two[`EXT_SEL_B_MSB:`EXT_SEL_B_LSB];
  assign can_load = !out_valid || out_ready;
  assign need_in  = (state != st_idle) && (!dir_tx || state == st_body);
  assign step     = (state != st_idle) && can_load && (!need_in || in_valid);
  assign in_ready = can_load && need_in;
  assign rem_dec  = remaining - 11'h001;
  assign seg_inc  = seg_cnt + 8'h01;

  assign wl.init = start;
  assign wl.din  = in_data;
  assign wl.step = step && state == st_body && white_on;  // [RULE9]

  always_comb begin
    if (state == st_len_hi) begin
      cur_byte = dir_tx ? {5'h00, len_q[10:8]} : in_data;
    end else if (state == st_len_lo) begin
      cur_byte = dir_tx ? len_q[7:0] : in_data;
    end else if (state == st_body) begin
      cur_byte = white_on ? wl.dout : in_data;  // [RULE9]
    end else begin
      cur_byte = dir_tx ? 8'h00 : in_data;
    end
  end

  // length as it stands once the last length byte is taken
  always_comb begin
    new_len = dir_tx ? len_q : {len_q[10:8], in_data};
    if (kind == kind_general) begin
      len_bad = (new_len < `CRC_BYTES);  // [RULE7]
    end else begin
      len_bad = (new_len < `MIN_LEN_B);  // [RULE4]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_crc   <= 1'b0;
    end else if (step) begin
      out_valid <= 1'b1;
      out_data  <= cur_byte;
      out_crc   <= (state == st_crc_a) || (state == st_crc_b);  // [RULE11]
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= st_idle;
      kind      <= kind_plain;
      dir_tx    <= 1'b0;
      white_on  <= 1'b0;
      len_q     <= 11'h000;
      remaining <= 11'h000;
      pos       <= 11'h000;
      seg_cnt   <= 8'h00;
      seg_idx   <= 2'd0;
      ext_seen  <= 1'b0;
      set_done  <= 1'b0;
      set_err   <= 1'b0;
    end else begin
      set_done <= 1'b0;
      set_err  <= 1'b0;
      if (start) begin
        dir_tx   <= pwdata[`CTRL_TX_BIT];
        len_q    <= pwdata[`CTRL_TX_BIT] ? tx_length : 11'h000;
        pos      <= 11'h000;
        seg_cnt  <= 8'h00;
        seg_idx  <= 2'd0;
        ext_seen <= 1'b0;
        white_on <= (fmt == `FMT_C) && data_settings_two[`WHITEN_EN_BIT];  // [RULE9]
        if (fmt == `FMT_C) begin
          kind  <= kind_general;  // [RULE5]
          state <= (packet_control_two[`LEN_MODE_MSB:`LEN_MODE_LSB] == `LEN_MODE_TWO)
                   ? st_len_hi : st_len_lo;  // [RULE8]
        end else if (fmt == `FMT_B) begin
          kind  <= kind_plain;  // [RULE10]
          state <= st_len_lo;
          if (pwdata[`CTRL_TX_BIT] && ext_a == `EXT_A_ELL && ext_b == `EXT_B_CI8E) begin
            kind <= kind_ci8e;  // [RULE1]
          end else if (pwdata[`CTRL_TX_BIT] && ext_a == `EXT_A_ELL
                       && ext_b == `EXT_B_CI8F) begin
            kind <= kind_ci8f;  // [RULE2]
          end
        end else begin
          set_err  <= 1'b1;
          set_done <= 1'b1;
        end
      end else if (step) begin
        case (state)
          st_len_hi: begin
            if (!dir_tx) begin
              len_q[10:8] <= in_data[2:0];
            end
            state <= st_len_lo;
          end
          st_len_lo: begin
            len_q     <= new_len;
            remaining <= new_len;
            if (len_bad) begin
              set_err  <= 1'b1;
              set_done <= 1'b1;
              state    <= st_idle;
            end else if (new_len == `CRC_BYTES) begin
              state <= st_crc_a;  // [RULE6]
            end else begin
              state <= st_body;
            end
          end
          st_body: begin
            remaining <= rem_dec;
            pos       <= pos + 11'h001;
            seg_cnt   <= seg_inc;
            if (!dir_tx && kind == kind_plain && pos == `CI_POS
                && !packet_control_one[`RX_EXT_DIS_BIT]) begin
              // this byte still lies inside the first block, which runs in format b layout
              if (in_data == `CI_EXT_8E) begin
                kind     <= kind_ci8e;  // [RULE3] [RULE4]
                ext_seen <= 1'b1;
              end else if (in_data == `CI_EXT_8F) begin
                kind     <= kind_ci8f;  // [RULE3] [RULE4]
                ext_seen <= 1'b1;
              end
            end
            if (rem_dec == `CRC_BYTES) begin
              state <= st_crc_a;  // [RULE6] [RULE7]
            end else if (kind != kind_general && seg_inc == seg_limit(kind, seg_idx)) begin
              state <= st_crc_a;  // [RULE11] [RULE12]
            end
          end
          st_crc_a: begin
            remaining <= rem_dec;
            state     <= st_crc_b;
          end
          st_crc_b: begin
            remaining <= rem_dec;
            seg_cnt   <= 8'h00;
            if (seg_idx != 2'd3) begin
              seg_idx <= seg_idx + 2'd1;
            end
            if (rem_dec == 11'h000) begin
              set_done <= 1'b1;
              state    <= st_idle;
            end else if (rem_dec == `CRC_BYTES) begin
              state <= st_crc_a;
            end else begin
              state <= st_body;  // [RULE11]
            end
          end
          default: begin
            state <= st_idle;
          end
        endcase
      end
    end
  end
endmodule // extended_link_and_general_framer

//--- verif/framer_chk.sv
// port-level assertions for the framer, bound to its top module
`include "framer_consts.svh"

module framer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic [7:0]  in_data,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [7:0]  out_data,
  input wire logic        out_crc
);
  // ----
  // helper state from software writes and accepted bytes
  // ----
  logic       acc;
  logic       unmapped;
  logic       crc_odd;
  logic       dir_tx;
  logic [1:0] fmt;
  assign acc = psel && penable;
  assign unmapped = !(paddr inside {12'h010, 12'h014, 12'h020, 12'h040, 12'h044, 12'h048,
                                    12'h04C});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_odd <= 1'b0;
    end else if (out_valid && out_ready && out_crc) begin
      crc_odd <= !crc_odd;
    end
  end
  // config writes while busy are ignored by the design, the bench never issues them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt <= 2'h0;
    end else if (acc && pwrite && paddr == 12'h010) begin
      fmt <= pwdata[1:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_tx <= 1'b0;
    end else if (acc && pwrite && paddr == 12'h040 && pwdata[0]) begin
      dir_tx <= pwdata[1];
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_stall;
    out_valid && !out_ready;
  endsequence
  sequence s_crc_last;
    out_valid && out_ready && out_crc && crc_odd;
  endsequence
  property p_pready;
    psel |-> pready;
  endproperty
  a_pready: assert property (p_pready) else $error("pready low in a transfer");
  property p_err_map;
    acc |-> pslverr == unmapped;
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  property p_err_idle;
    !acc |-> !pslverr;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
  property p_rd_zero;
    acc && !pwrite && unmapped |-> prdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read data not zero");
  property p_hold;
    s_stall |=> out_valid && $stable(out_data) && $stable(out_crc);
  endproperty
  a_hold: assert property (p_hold) else $error("output byte changed while stalled");
  property p_refuse;
    s_stall |-> !in_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("input taken while output stalled");
  property p_crc_pair;
    out_valid && out_ready && !out_crc |-> !crc_odd;
  endproperty
  a_crc_pair: assert property (p_crc_pair) else $error("crc slots not paired");
  property p_tx_crc;
    out_valid && out_crc && dir_tx |-> out_data == 8'h00;
  endproperty
  a_tx_crc: assert property (p_tx_crc) else $error("transmit crc slot not empty");
  property p_c_single;
    s_crc_last ##0 fmt == `FMT_C |=> !out_valid [*3];
  endproperty
  a_c_single: assert property (p_c_single) else $error("bytes after format c crc");
endmodule // framer_chk

bind extended_link_and_general_framer framer_chk chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
  .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
  .out_data(out_data), .out_crc(out_crc));

//--- verif/stream_node.sv
// far-side byte node: feeds the input stream and collects the output stream
module stream_node (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic            in_valid,
  output logic      [7:0] in_data,
  input  wire logic       in_ready,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_crc,
  output logic            out_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] src_q[$];
  logic [8:0] snk_q[$];
  logic       slow;
  logic [1:0] cnt;
  initial begin
    slow = 1'b0;
    in_valid = 1'b0;
    in_data = 8'h00;
    out_ready = 1'b0;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_valid  <= 1'b0;
      out_ready <= 1'b0;
      cnt       <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
      // slow mode accepts one byte in four
      out_ready <= !slow || cnt == 2'h3;
      if (out_valid && out_ready) begin
        snk_q.push_back({out_crc, out_data});
      end
      if (in_valid && in_ready) begin
        void'(src_q.pop_front());
      end
      if (src_q.size() > 0) begin
        in_valid <= 1'b1;
        in_data  <= src_q[0];
      end else begin
        in_valid <= 1'b0;
        // a released line alternates between the last byte and its inverse
        in_data  <= ~in_data;
      end
    end
  end
endmodule // stream_node

//--- verif/extended_link_and_general_framer_bench.sv
// self-checking bench for the framer
`include "framer_consts.svh"

module extended_link_and_general_framer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] pc1 = 12'h010;
  localparam logic [11:0] pc2 = 12'h014;
  localparam logic [11:0] ds2 = 12'h020;
  localparam logic [11:0] fctl = 12'h040;
  localparam logic [11:0] txl = 12'h044;
  localparam logic [11:0] stat = 12'h048;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        in_valid, in_ready, out_valid, out_ready, out_crc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, st;
  logic [7:0]  in_data, out_data;
  logic [31:0] rnd;
  logic [7:0]  pay[$];
  logic [7:0]  w[$];
  logic [8:0]  exp_q[$];
  int          errors, checks_done, n;
  logic [11:0] ra[3] = '{pc1, pc2, ds2};
  logic [31:0] rm[3] = '{32'hCB, 32'h03, 32'hC1};
  int          lens[3] = '{2, 3, 261};
  logic [1:0]  bad_f[4] = '{`FMT_C, `FMT_B, 2'h0, 2'h3};
  int          bad_l[4] = '{1, 11, 3, 3};

  always #5 pclk = ~pclk;

  extended_link_and_general_framer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_crc(out_crc));
  stream_node node (.pclk(pclk), .presetn(presetn), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_crc(out_crc),
    .out_ready(out_ready));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      errors++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic make_pay(input int cnt);
    pay.delete();
    repeat (cnt) begin
      rnd = lfsr(rnd);
      pay.push_back(rnd[7:0]);
    end
  endtask
  // model of the wire image: length field, body, two crc slots
  task automatic frame(input logic tx, input logic [7:0] c1, input logic [7:0] c2,
                       input logic [7:0] s2, input int len);
    apb(1'b1, pc1, {24'h0, c1});
    apb(1'b1, pc2, {24'h0, c2});
    apb(1'b1, ds2, {24'h0, s2});
    apb(1'b1, txl, len);
    exp_q.delete();
    node.snk_q.delete();
    if (c2[1:0] == `LEN_MODE_TWO) begin
      exp_q.push_back({6'h0, len[10:8]});
    end
    exp_q.push_back({1'b0, len[7:0]});
    foreach (pay[i]) exp_q.push_back({1'b0, pay[i]});
    exp_q.push_back(9'h100);
    exp_q.push_back(9'h100);
    if (tx) begin
      foreach (pay[i]) node.src_q.push_back(pay[i]);
    end else begin
      foreach (exp_q[i]) node.src_q.push_back(exp_q[i][7:0]);
    end
    apb(1'b1, fctl, {30'h0, tx, 1'b1});
    // q still holds an older read, so force at least one status poll
    q = 32'h0000_0001;
    for (n = 0; n < 3000 && q[0] !== 1'b0; n++) begin
      apb(1'b0, stat, 32'h0);
    end
    if (n == 3000) begin
      errors++;
      results();
    end
    st = q;
    apb(1'b1, stat, 32'h6);
    node.src_q.delete();
  endtask
  task automatic cmp_stream();
    check("stream size", node.snk_q.size(), exp_q.size());
    foreach (exp_q[i]) check("stream byte", node.snk_q[i], exp_q[i]);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rnd = 32'h13B7;
    errors = 0;
    checks_done = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check("reset value", q, 32'h0);
      for (int j = 0; j < 4; j++) begin
        rnd = lfsr(rnd);
        apb(1'b1, ra[i], rnd);
        apb(1'b0, ra[i], 32'h0);
        check("field readback", q & rm[i], rnd & rm[i]);
      end
    end
    apb(1'b0, 12'h0FC, 32'h0);
    check("unmapped error", e, 1'b1);
    check("unmapped data", q, 32'h0);
    // format c transmit: empty body, one-byte and two-byte length, slow sink
    foreach (lens[i]) begin
      make_pay(lens[i] - 2);
      node.slow = (i == 2);
      frame(1'b1, {6'h0, `FMT_C}, (i == 2) ? 8'h01 : 8'h00, 8'h00, lens[i]);
      cmp_stream();
      check("done flag", st[1], 1'b1);
    end
    node.slow = 1'b0;
    pay.delete();
    foreach (bad_f[i]) begin
      frame(1'b1, {6'h0, bad_f[i]}, 8'h00, 8'h00, bad_l[i]);
      check("length error", st[2], 1'b1);
    end
    for (int k = 1; k < 3; k++) begin
      make_pay(10);
      frame(1'b1, {6'h0, `FMT_B}, 8'h00, {k[1:0], 6'h0}, 12);
      cmp_stream();
      check("tx kind", st[9:8], k);
    end
    // receive with the extended check on, then off
    for (int k = 0; k < 4; k++) begin
      make_pay(18);
      pay[`CI_POS] = k[0] ? `CI_EXT_8F : `CI_EXT_8E;
      frame(1'b0, {4'h0, k[1], 1'b0, `FMT_B}, 8'h00, 8'h00, 20);
      cmp_stream();
      check("ext seen", st[3], !k[1]);
      check("rx kind", st[9:8], k[1] ? 0 : k[0] + 1);
    end
    make_pay(8);
    w = pay;
    frame(1'b1, {6'h0, `FMT_C}, 8'h00, 8'h01, 10);
    check("length plain", node.snk_q[0], 9'h00A);
    check("crc slot", node.snk_q[9], 9'h100);
    // an all-ones pn9 seed yields eight ones for the first body byte
    check("whitened", node.snk_q[1][7:0], w[0] ^ 8'hFF);
    foreach (pay[i]) pay[i] = node.snk_q[i + 1][7:0];
    frame(1'b0, {6'h0, `FMT_C}, 8'h00, 8'h01, 10);
    n = node.snk_q.size() - 10;
    foreach (w[i]) check("dewhitened", node.snk_q[n + i][7:0], w[i]);
    results();
  end
endmodule // extended_link_and_general_framer_bench
